// ---- src/sdoc_bank.sv ----
// AXI4-Lite register bank for synthesizer divider, output and calibration config
//
// The AXI4-Lite register port was decided locally.
`include "sdoc_regs.svh"

// How it works
// - Dither bit 10 of modulator word randomizes modulator; off by default.
// - Distribution bits 10/9 power down oscillator buffers B/A; defaults 1 and 0.
// - Divider enable bit 5 enables the whole channel divider; default enabled.
// - Stage two/three ratio codes 8,4,2,1 give divide 8,6,4,2; 0 powers down.
// - Stage one ratio bit 2 selects divide 3 or 2; default 3.
// - Bits 8,7,1 enable stages three, two, one; all default off.
// - Stage select 4,2,1 uses three, two, one stages; 0 powers chain down.
// - Bits 11/10 enable divider buffers to outputs B/A; defaults 0 and 1.
// - Prescaler bit 12 selects divide by 4 or by 2.
// - Integer divide value sits in bits 12:1, reset value 27.
// - Delay codes 1,2,4,8,16 give 4,6,8,12,16 cycles; 32 unused; default 2.
// - Denominator split high then low words, each defaulting to 1000.
// - Numerator split into high and low words, both zero by default.
// - Output levels A 13:8, B 5:0; 0-31 and 48-63; defaults 15 and 0.
// - Bits 7/6 power down output buffers B/A; defaults 1 and 0.
// - Modulator order 0 integer, 1 to 4 order; default third order.
// - Source select 1 routes oscillator, 0 divider; 2 and 3 reserved.
// - Status pin shows calibration done at kind 0, tuning lock at kind 1.
// - Read-only bits 10:9 report tuning detector: unlocked, invalid, locked, unlocked.
// - Read-only calibration core 7:5, capacitor code 7:0, amplitude code 8:0.
// - Bits 9/8 enable fast amplitude/frequency cal; steps 7:5 and 3:0.
module sdoc_bank
  import sdoc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [8:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [8:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cal_done_pin,
  input  wire logic [1:0]  tune_lock_pin,
  input  wire logic [2:0]  cal_core_pin,
  input  wire logic [7:0]  cal_cap_pin,
  input  wire logic [8:0]  cal_amp_pin,
  output logic             status_pin,
  output logic             modulator_dither,
  output logic [2:0]       modulator_order,
  output logic [31:0]      modulator_seed,
  output logic [31:0]      fraction_denominator,
  output logic [31:0]      fraction_numerator,
  output logic [11:0]      feedback_n,
  output logic [2:0]       prescale_ratio,
  output logic [4:0]       detector_delay_cycles,
  output logic             osc_to_out_a_buffer_off,
  output logic             osc_to_out_b_buffer_off,
  output logic             divider_chain_enable,
  output logic [3:0]       chain_ratio_one,
  output logic [3:0]       chain_ratio_two,
  output logic [3:0]       chain_ratio_three,
  output logic [2:0]       stage_power,
  output logic             divider_to_out_a_enable,
  output logic             divider_to_out_b_enable,
  output logic [5:0]       out_a_level,
  output logic [5:0]       out_b_level,
  output logic             out_a_power_off,
  output logic             out_b_power_off,
  output logic [1:0]       out_a_source,
  output logic [1:0]       out_b_source,
  output logic             fast_amplitude_cal,
  output logic             fast_frequency_cal,
  output logic [2:0]       amplitude_step,
  output logic [3:0]       frequency_step
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  localparam int NREG = 128;
  sdoc_word_t mem [NREG];
  logic       [NREG-1:0] rw_map;
  logic       [NREG-1:0] ro_map;
  sdoc_word_t rst_val [NREG];

  // ----------------------------------------------------------------
  // Synchronised pin inputs
  // ----------------------------------------------------------------
  logic [22:0] pin_s1;
  logic [22:0] pin_s2;
  wire  [22:0] pin_raw = {cal_done_pin, tune_lock_pin, cal_core_pin, cal_cap_pin, cal_amp_pin};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end
    else if (clk_en)
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  wire       done_s = pin_s2[22];
  wire [1:0] lock_s = pin_s2[21:20];
  wire [2:0] core_s = pin_s2[19:17];
  wire [7:0] cap_s  = pin_s2[16:9];
  wire [8:0] amp_s  = pin_s2[8:0];

  // ----------------------------------------------------------------
  // Map of writable words and their reset values
  // ----------------------------------------------------------------
  always_comb
  begin
    rw_map = '0;
    ro_map = '0;
    for (int i = 0; i < NREG; i++)
      rst_val[i] = `SDOC_RST_ZERO;
    rw_map[`SDOC_IDX_RSV28]     = 1'b1;
    rw_map[`SDOC_IDX_RSV29]     = 1'b1;
    rw_map[`SDOC_IDX_DITHER]    = 1'b1;
    rw_map[`SDOC_IDX_OSC_DIST]  = 1'b1;
    rw_map[`SDOC_IDX_RSV32]     = 1'b1;
    rw_map[`SDOC_IDX_RSV33]     = 1'b1;
    rw_map[`SDOC_IDX_DIV_EN]    = 1'b1;
    rw_map[`SDOC_IDX_DIV_STAGE] = 1'b1;
    rw_map[`SDOC_IDX_DIV_ROUTE] = 1'b1;
    rw_map[`SDOC_IDX_FB_PRE]    = 1'b1;
    rw_map[`SDOC_IDX_FB_INT]    = 1'b1;
    rw_map[`SDOC_IDX_PD_DLY]    = 1'b1;
    rw_map[`SDOC_IDX_DEN_HI]    = 1'b1;
    rw_map[`SDOC_IDX_DEN_LO]    = 1'b1;
    rw_map[`SDOC_IDX_SEED_HI]   = 1'b1;
    rw_map[`SDOC_IDX_SEED_LO]   = 1'b1;
    rw_map[`SDOC_IDX_NUM_HI]    = 1'b1;
    rw_map[`SDOC_IDX_NUM_LO]    = 1'b1;
    rw_map[`SDOC_IDX_OUTA_LVL]  = 1'b1;
    rw_map[`SDOC_IDX_OUTA_SRC]  = 1'b1;
    rw_map[`SDOC_IDX_OUTB_SRC]  = 1'b1;
    rw_map[`SDOC_IDX_STAT_PIN]  = 1'b1;
    rw_map[`SDOC_IDX_LD_SEL]    = 1'b1;
    rw_map[`SDOC_IDX_RSV62]     = 1'b1;
    rw_map[`SDOC_IDX_FAST_CAL]  = 1'b1;
    ro_map[`SDOC_IDX_RB_CORE]   = 1'b1;
    ro_map[`SDOC_IDX_RB_CAP]    = 1'b1;
    ro_map[`SDOC_IDX_RB_AMP]    = 1'b1;
    rst_val[`SDOC_IDX_DITHER]    = `SDOC_RST_DITHER;
    rst_val[`SDOC_IDX_OSC_DIST]  = `SDOC_RST_OSC_DIST;
    rst_val[`SDOC_IDX_DIV_EN]    = `SDOC_RST_DIV_EN;
    rst_val[`SDOC_IDX_DIV_STAGE] = `SDOC_RST_DIV_STAGE;
    rst_val[`SDOC_IDX_DIV_ROUTE] = `SDOC_RST_DIV_ROUTE;
    rst_val[`SDOC_IDX_FB_INT]    = `SDOC_RST_FB_INT;
    rst_val[`SDOC_IDX_PD_DLY]    = `SDOC_RST_PD_DLY;
    rst_val[`SDOC_IDX_DEN_HI]    = `SDOC_RST_DEN;
    rst_val[`SDOC_IDX_DEN_LO]    = `SDOC_RST_DEN;
    rst_val[`SDOC_IDX_OUTA_LVL]  = `SDOC_RST_OUTA_LVL;
    rst_val[`SDOC_IDX_LD_SEL]    = `SDOC_RST_LD_SEL;
    rst_val[`SDOC_IDX_FAST_CAL]  = `SDOC_RST_FAST_CAL;
  end

  // ----------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ----------------------------------------------------------------
  logic       aw_held;
  logic       w_held;
  logic [6:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  assign s_axi_awready = clk_en && !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = clk_en && !w_held && !s_axi_bvalid;

  wire       aw_take  = s_axi_awvalid && s_axi_awready;
  wire       w_take   = s_axi_wvalid && s_axi_wready;
  wire       aw_have  = aw_held || aw_take;
  wire       w_have   = w_held || w_take;
  wire [6:0] wr_idx   = aw_held ? aw_idx : s_axi_awaddr[8:2];
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb  = w_held ? w_strb : s_axi_wstrb;
  wire       wr_fire  = clk_en && aw_have && w_have && !s_axi_bvalid;
  wire       wr_hit   = rw_map[wr_idx];
  wire [15:0] strb_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_idx       <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= SDOC_RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (wr_fire)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? SDOC_RESP_OKAY : SDOC_RESP_SLVERR;
      end
      else
      begin
        if (aw_take)
        begin
          aw_held <= 1'b1;
          aw_idx  <= s_axi_awaddr[8:2];
        end
        if (w_take)
        begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Only the fields' own storage changes; unmapped writes leave the file intact
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NREG; i++)
        mem[i] <= rst_val[i];
    end
    else if (wr_fire && wr_hit)
      mem[wr_idx] <= (mem[wr_idx] & ~strb_mask) | (wr_data[15:0] & strb_mask);
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  wire [6:0] rd_idx = s_axi_araddr[8:2];
  assign s_axi_arready = clk_en && !s_axi_rvalid;
  wire rd_take = s_axi_arvalid && s_axi_arready;

  // Readback words are built from live calibration results
  wire [15:0] rb_core_word = (16'(lock_s) << `SDOC_SH_LD_VTUNE)
                           | (16'(core_s) << `SDOC_SH_CORE);
  wire [15:0] rb_cap_word  = 16'(cap_s);
  wire [15:0] rb_amp_word  = 16'(amp_s);
  wire [15:0] rd_word =
    (rd_idx == `SDOC_IDX_RB_CORE) ? rb_core_word :
    (rd_idx == `SDOC_IDX_RB_CAP)  ? rb_cap_word  :
    (rd_idx == `SDOC_IDX_RB_AMP)  ? rb_amp_word  :
    rw_map[rd_idx]                ? mem[rd_idx]  : 16'h0000;
  wire rd_hit = rw_map[rd_idx] || ro_map[rd_idx];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= SDOC_RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (rd_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rd_word};
        s_axi_rresp  <= rd_hit ? SDOC_RESP_OKAY : SDOC_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire [15:0] r_dith  = mem[`SDOC_IDX_DITHER];
  wire [15:0] r_dist  = mem[`SDOC_IDX_OSC_DIST];
  wire [15:0] r_den   = mem[`SDOC_IDX_DIV_EN];
  wire [15:0] r_stg   = mem[`SDOC_IDX_DIV_STAGE];
  wire [15:0] r_rte   = mem[`SDOC_IDX_DIV_ROUTE];
  wire [15:0] r_lvla  = mem[`SDOC_IDX_OUTA_LVL];
  wire [15:0] r_srca  = mem[`SDOC_IDX_OUTA_SRC];
  wire [15:0] r_fast  = mem[`SDOC_IDX_FAST_CAL];
  wire [5:0]  dly_code = mem[`SDOC_IDX_PD_DLY][`SDOC_F_PD_DLY];
  wire [2:0]  seg_sel  = r_rte[`SDOC_F_SEG_SEL];

  function automatic logic [3:0] seg_ratio(input logic [3:0] code);
    case (code)
      `SDOC_RAT_8: seg_ratio = 4'h8;
      `SDOC_RAT_6: seg_ratio = 4'h6;
      `SDOC_RAT_4: seg_ratio = 4'h4;
      `SDOC_RAT_2: seg_ratio = 4'h2;
      default:     seg_ratio = 4'h0;
    endcase
  endfunction

  // Undocumented delay codes, the forbidden one included, fall back to zero
  function automatic logic [4:0] dly_cycles(input logic [5:0] code);
    case (code)
      6'h01:   dly_cycles = 5'h04;
      6'h02:   dly_cycles = 5'h06;
      6'h04:   dly_cycles = 5'h08;
      6'h08:   dly_cycles = 5'h0c;
      6'h10:   dly_cycles = 5'h10;
      default: dly_cycles = 5'h00;
    endcase
  endfunction

  // Stage in use only when chain, selector and its own enable all agree
  wire [2:0] sel_use =
    (seg_sel == `SDOC_SEL_THREE) ? 3'b111 :
    (seg_sel == `SDOC_SEL_TWO)   ? 3'b011 :
    (seg_sel == `SDOC_SEL_ONE)   ? 3'b001 : 3'b000;
  wire [2:0] own_en = {r_stg[`SDOC_B_SEG3_EN], r_stg[`SDOC_B_SEG2_EN],
                       r_stg[`SDOC_B_SEG1_EN]};
  wire       chain_on = r_den[`SDOC_B_CHAIN_EN];
  wire [2:0] next_stage_power = {3{chain_on}} & sel_use & own_en;
  wire       lock_ok = (lock_s == 2'h2);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_pin            <= 1'b0;
      detector_delay_cycles <= '0;
      stage_power           <= '0;
      chain_ratio_one       <= '0;
      chain_ratio_two       <= '0;
      chain_ratio_three     <= '0;
      prescale_ratio        <= '0;
    end
    else if (clk_en)
    begin
      status_pin <= mem[`SDOC_IDX_LD_SEL][`SDOC_B_LD_KIND] ? lock_ok : done_s;
      detector_delay_cycles <= dly_cycles(dly_code);
      stage_power       <= next_stage_power;
      chain_ratio_one   <= r_stg[`SDOC_B_SEG1] ? 4'h3 : 4'h2;
      chain_ratio_two   <= seg_ratio(r_stg[`SDOC_F_SEG2]);
      chain_ratio_three <= seg_ratio(r_rte[`SDOC_F_SEG3]);
      prescale_ratio    <= mem[`SDOC_IDX_FB_PRE][`SDOC_B_PRESCALE] ? 3'h4 : 3'h2;
    end
  end

  // Plain field views straight from storage
  assign modulator_dither        = r_dith[`SDOC_B_DITHER];
  assign modulator_order         = r_lvla[`SDOC_F_ORDER];
  assign modulator_seed          = {mem[`SDOC_IDX_SEED_HI], mem[`SDOC_IDX_SEED_LO]};
  assign fraction_denominator    = {mem[`SDOC_IDX_DEN_HI], mem[`SDOC_IDX_DEN_LO]};
  assign fraction_numerator      = {mem[`SDOC_IDX_NUM_HI], mem[`SDOC_IDX_NUM_LO]};
  assign feedback_n              = mem[`SDOC_IDX_FB_INT][`SDOC_F_N_INT];
  assign osc_to_out_b_buffer_off = r_dist[`SDOC_B_OSC_B_OFF];
  assign osc_to_out_a_buffer_off = r_dist[`SDOC_B_OSC_A_OFF];
  assign divider_chain_enable    = chain_on;
  assign divider_to_out_b_enable = r_rte[`SDOC_B_DIV_B_EN];
  assign divider_to_out_a_enable = r_rte[`SDOC_B_DIV_A_EN];
  assign out_a_level             = r_lvla[`SDOC_F_OUTA_LVL];
  assign out_b_level             = r_srca[`SDOC_F_OUTB_LVL];
  assign out_b_power_off         = r_lvla[`SDOC_B_OUTB_OFF];
  assign out_a_power_off         = r_lvla[`SDOC_B_OUTA_OFF];
  assign out_a_source            = r_srca[`SDOC_F_OUTA_SRC];
  assign out_b_source            = mem[`SDOC_IDX_OUTB_SRC][`SDOC_F_OUTB_SRC];
  assign fast_amplitude_cal      = r_fast[`SDOC_B_FAST_AMP];
  assign fast_frequency_cal      = r_fast[`SDOC_B_FAST_FRQ];
  assign amplitude_step          = r_fast[`SDOC_F_AMP_STEP];
  assign frequency_step          = r_fast[`SDOC_F_FRQ_STEP];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_wr_done;
    wr_fire ##1 s_axi_bvalid;
  endsequence

  property p_wr_resp;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid && (s_axi_bresp == (($past(wr_hit)) ? 2'b00 : 2'b10));
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response wrong");

  property p_den_write;
    @(posedge aclk) disable iff (!aresetn)
      (wr_fire && wr_idx == `SDOC_IDX_DEN_LO && wr_strb == 4'hf)
        |=> fraction_denominator[15:0] == $past(wr_data[15:0]);
  endproperty
  a_den_write: assert property (p_den_write) else $error("denominator low not stored");

  property p_num_split;
    @(posedge aclk) disable iff (!aresetn)
      (wr_fire && wr_idx == `SDOC_IDX_NUM_HI && wr_strb[1:0] == 2'b11)
        |=> fraction_numerator[31:16] == $past(wr_data[15:0]);
  endproperty
  a_num_split: assert property (p_num_split) else $error("numerator high half misplaced");

  property p_stage_off;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && !chain_on) |=> stage_power == 3'b000;
  endproperty
  a_stage_off: assert property (p_stage_off) else $error("stage powered with chain off");

  property p_sel_one;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && seg_sel == `SDOC_SEL_ONE) |=> stage_power[2:1] == 2'b00;
  endproperty
  a_sel_one: assert property (p_sel_one) else $error("extra stage on with select one");

  property p_dly;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && dly_code == 6'h08) |=> detector_delay_cycles == 5'h0c;
  endproperty
  a_dly: assert property (p_dly) else $error("delay decode wrong");

  property p_ratio;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && r_stg[`SDOC_F_SEG2] == `SDOC_RAT_6) |=> chain_ratio_two == 4'h6;
  endproperty
  a_ratio: assert property (p_ratio) else $error("stage two ratio wrong");

  property p_lock_pin;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && mem[`SDOC_IDX_LD_SEL][0] && lock_s == 2'h2) |=> status_pin;
  endproperty
  a_lock_pin: assert property (p_lock_pin) else $error("status pin low while locked");

  property p_rd_ro;
    @(posedge aclk) disable iff (!aresetn)
      (rd_take && rd_idx == `SDOC_IDX_RB_CAP) |=> s_axi_rvalid && s_axi_rdata[31:8] == '0;
  endproperty
  a_rd_ro: assert property (p_rd_ro) else $error("capacitor readback upper bits set");

  property p_bhold;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");

endmodule

// ---- inc/sdoc_regs.svh ----
// Register offsets, field positions and reset values of the synthesizer config bank
`ifndef SDOC_REGS_SVH
`define SDOC_REGS_SVH

// Register indices; byte address is four times the index
`define SDOC_IDX_RSV28        7'h1c
`define SDOC_IDX_RSV29        7'h1d
`define SDOC_IDX_DITHER       7'h1e
`define SDOC_IDX_OSC_DIST     7'h1f
`define SDOC_IDX_RSV32        7'h20
`define SDOC_IDX_RSV33        7'h21
`define SDOC_IDX_DIV_EN       7'h22
`define SDOC_IDX_DIV_STAGE    7'h23
`define SDOC_IDX_DIV_ROUTE    7'h24
`define SDOC_IDX_FB_PRE       7'h25
`define SDOC_IDX_FB_INT       7'h26
`define SDOC_IDX_PD_DLY       7'h27
`define SDOC_IDX_DEN_HI       7'h28
`define SDOC_IDX_DEN_LO       7'h29
`define SDOC_IDX_SEED_HI      7'h2a
`define SDOC_IDX_SEED_LO      7'h2b
`define SDOC_IDX_NUM_HI       7'h2c
`define SDOC_IDX_NUM_LO       7'h2d
`define SDOC_IDX_OUTA_LVL     7'h2e
`define SDOC_IDX_OUTA_SRC     7'h2f
`define SDOC_IDX_OUTB_SRC     7'h30
`define SDOC_IDX_STAT_PIN     7'h3b
`define SDOC_IDX_LD_SEL       7'h3d
`define SDOC_IDX_RSV62        7'h3e
`define SDOC_IDX_FAST_CAL     7'h40
`define SDOC_IDX_RB_CORE      7'h44
`define SDOC_IDX_RB_CAP       7'h45
`define SDOC_IDX_RB_AMP       7'h46

// Reset values of whole words
`define SDOC_RST_ZERO         16'h0000
`define SDOC_RST_DITHER       16'h0000
`define SDOC_RST_OSC_DIST     16'h0400
`define SDOC_RST_DIV_EN       16'h0020
`define SDOC_RST_DIV_STAGE    16'h0204
`define SDOC_RST_DIV_ROUTE    16'h0411
`define SDOC_RST_FB_INT       16'h0036
`define SDOC_RST_PD_DLY       16'h0200
`define SDOC_RST_DEN          16'h03e8
`define SDOC_RST_OUTA_LVL     16'h0f83
`define SDOC_RST_OUTA_SRC     16'h0000
`define SDOC_RST_LD_SEL       16'h0001
`define SDOC_RST_FAST_CAL     16'h006f

// Field positions
`define SDOC_B_DITHER         10
`define SDOC_F_TUNE_ADJ       7:6
`define SDOC_B_OSC_B_OFF      10
`define SDOC_B_OSC_A_OFF      9
`define SDOC_B_CHAIN_EN       5
`define SDOC_F_SEG2           12:9
`define SDOC_B_SEG3_EN        8
`define SDOC_B_SEG2_EN        7
`define SDOC_B_SEG1           2
`define SDOC_B_SEG1_EN        1
`define SDOC_B_DIV_B_EN       11
`define SDOC_B_DIV_A_EN       10
`define SDOC_F_SEG_SEL        6:4
`define SDOC_F_SEG3           3:0
`define SDOC_B_PRESCALE       12
`define SDOC_F_N_INT          12:1
`define SDOC_F_PD_DLY         13:8
`define SDOC_F_OUTA_LVL       13:8
`define SDOC_B_OUTB_OFF       7
`define SDOC_B_OUTA_OFF       6
`define SDOC_F_ORDER          2:0
`define SDOC_F_OUTA_SRC       12:11
`define SDOC_F_OUTB_LVL       5:0
`define SDOC_F_OUTB_SRC       1:0
`define SDOC_B_LD_KIND        0
`define SDOC_B_MUX_SEL        0
`define SDOC_B_FAST_AMP       9
`define SDOC_B_FAST_FRQ       8
`define SDOC_F_AMP_STEP       7:5
`define SDOC_F_FRQ_STEP       3:0
`define SDOC_SH_LD_VTUNE      9
`define SDOC_SH_CORE          5

// Stage ratio codes and resulting divide values
`define SDOC_RAT_8            4'h8
`define SDOC_RAT_6            4'h4
`define SDOC_RAT_4            4'h2
`define SDOC_RAT_2            4'h1
`define SDOC_SEL_THREE        3'h4
`define SDOC_SEL_TWO          3'h2
`define SDOC_SEL_ONE          3'h1
`define SDOC_DLY_FORBIDDEN    6'h20
`define SDOC_SRC_OSC          2'h1
`define SDOC_SRC_DIV          2'h0
`define SDOC_ORDER_MAX        3'h4

`endif

// ---- inc/sdoc_pkg.sv ----
// Types shared by the synthesizer config bank
package sdoc_pkg;
  typedef enum logic [1:0]
  {
    SDOC_RESP_OKAY   = 2'b00,
    SDOC_RESP_SLVERR = 2'b10
  } sdoc_resp_t;
  typedef logic [15:0] sdoc_word_t;
endpackage

// ---- testbench/tb.sv ----
// Self-checking bench for the synthesizer config bank
`include "sdoc_regs.svh"
module tb
  import sdoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 0, aresetn = 0, clk_en = 1, cal_done_pin = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic        s_axi_bready = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic        s_axi_arready, s_axi_bvalid, s_axi_rvalid, status_pin, modulator_dither;
  logic        osc_to_out_a_buffer_off, osc_to_out_b_buffer_off, divider_chain_enable;
  logic        divider_to_out_a_enable, divider_to_out_b_enable, out_a_power_off;
  logic        out_b_power_off, fast_amplitude_cal, fast_frequency_cal;
  logic [1:0]  tune_lock_pin = 0, s_axi_bresp, s_axi_rresp, out_a_source, out_b_source, r;
  logic [2:0]  cal_core_pin = 0, modulator_order, prescale_ratio, stage_power, amplitude_step;
  logic [3:0]  s_axi_wstrb = 4'hf, chain_ratio_one, chain_ratio_two, chain_ratio_three;
  logic [3:0]  frequency_step;
  logic [4:0]  detector_delay_cycles;
  logic [5:0]  out_a_level, out_b_level;
  logic [7:0]  cal_cap_pin = 0;
  logic [8:0]  s_axi_awaddr = 0, s_axi_araddr = 0, cal_amp_pin = 0;
  logic [11:0] feedback_n;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, modulator_seed, fraction_denominator;
  logic [31:0] fraction_numerator, d, a;
  logic [15:0] lv, fc;
  int          n_errors = 0, check_count = 0, cyc = 0;
  logic [6:0]  ri[8] = '{`SDOC_IDX_DEN_HI, `SDOC_IDX_DEN_LO, `SDOC_IDX_NUM_LO, `SDOC_IDX_OUTA_LVL,
                         `SDOC_IDX_FB_INT, `SDOC_IDX_PD_DLY, `SDOC_IDX_OSC_DIST, `SDOC_IDX_FAST_CAL};
  logic [15:0] rv[8] = '{`SDOC_RST_DEN, `SDOC_RST_DEN, `SDOC_RST_ZERO, `SDOC_RST_OUTA_LVL,
                         `SDOC_RST_FB_INT, `SDOC_RST_PD_DLY, `SDOC_RST_OSC_DIST, `SDOC_RST_FAST_CAL};
  logic [5:0]  dc[6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
  logic [4:0]  dy[6] = '{5'h04, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h00};
  logic [3:0]  sc[5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0};
  logic [3:0]  sv[5] = '{4'h8, 4'h6, 4'h4, 4'h2, 4'h0};

  sdoc_bank sdoc_bank_i (.*);

  always #10 aclk = ~aclk;

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_errors++;
      end_sim();
    end
  end

  task end_sim;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // ----
  // One AXI4-Lite transfer; handshakes sampled mid-cycle, stable up to the edge
  // ----
  task automatic bus(input logic wn, input logic [6:0] i, input logic [15:0] v,
                     output logic [1:0] rs, output logic [31:0] rdv);
    logic ta, tw, tr, t;
    @(posedge aclk);
    s_axi_awaddr  <= {i, 2'b00};
    s_axi_araddr  <= {i, 2'b00};
    s_axi_wdata   <= {16'h0000, v};
    s_axi_awvalid <= wn;
    s_axi_wvalid  <= wn;
    s_axi_arvalid <= !wn;
    s_axi_bready  <= wn;
    s_axi_rready  <= !wn;
    do
    begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tr = s_axi_arvalid & s_axi_arready;
      t = (s_axi_bvalid & s_axi_bready) | (s_axi_rvalid & s_axi_rready);
      rs = wn ? s_axi_bresp : s_axi_rresp;
      rdv = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tr) s_axi_arvalid <= 0;
    end
    while (!t);
    s_axi_bready <= 0;
    s_axi_rready <= 0;
  endtask

  // Covers the decode register and the two-stage pin synchronizer
  task settle;
    repeat (4) @(negedge aclk);
  endtask

  initial
  begin
    void'($urandom(32'hb0474fcb));
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    settle;
    chk("rst_outs", {feedback_n, detector_delay_cycles, osc_to_out_b_buffer_off,
        divider_chain_enable, modulator_dither, osc_to_out_a_buffer_off, divider_to_out_a_enable,
        divider_to_out_b_enable},
        {12'h01b, 5'h06, 6'b110010});
    chk("den", 32'h03e8_03e8, fraction_denominator);
    foreach (ri[k])
    begin
      bus(0, ri[k], 16'h0000, r, d);
      chk("rst_word", {16'h0000, rv[k]}, d);
    end
    bus(1, `SDOC_IDX_DITHER, 16'h04c0, r, d);
    bus(0, `SDOC_IDX_DITHER, 16'h0000, r, d);
    chk("tune_adj", 32'h0000_04c0, d);
    settle;
    chk("dither", 1'b1, modulator_dither);
    foreach (dc[k])
    begin
      bus(1, `SDOC_IDX_PD_DLY, {2'b00, dc[k], 8'h00}, r, d);
      settle;
      chk("delay", dy[k], detector_delay_cycles);
    end
    foreach (sc[k])
    begin
      bus(1, `SDOC_IDX_DIV_STAGE, {3'h0, sc[k], 2'b11, 4'h0, k[0], 2'b10}, r, d);
      bus(1, `SDOC_IDX_DIV_ROUTE, {6'h01, 3'h0, k[0], 2'b00, sc[k]}, r, d);
      bus(1, `SDOC_IDX_FB_PRE, {3'h0, k[0], 12'h000}, r, d);
      settle;
      chk("ratio", {sv[k], sv[k]}, {chain_ratio_two, chain_ratio_three});
      chk("seg1", k[0] ? 4'h3 : 4'h2, chain_ratio_one);
      chk("pre", k[0] ? 3'h4 : 3'h2, prescale_ratio);
      chk("power", k[0] ? 3'h7 : 3'h0, stage_power);
    end
    bus(1, `SDOC_IDX_DIV_ROUTE, 16'h0441, r, d);
    bus(1, `SDOC_IDX_DIV_EN, 16'h0000, r, d);
    settle;
    chk("chain_off", 4'h0, {divider_chain_enable, stage_power});
    repeat (4)
    begin
      a = $urandom;
      bus(1, `SDOC_IDX_NUM_HI, a[31:16], r, d);
      bus(1, `SDOC_IDX_NUM_LO, a[15:0], r, d);
      bus(1, `SDOC_IDX_DEN_LO, a[31:16], r, d);
      bus(1, `SDOC_IDX_SEED_HI, a[15:0], r, d);
      bus(1, `SDOC_IDX_SEED_LO, a[31:16], r, d);
      settle;
      chk("num", a, fraction_numerator);
      chk("den_lo", {`SDOC_RST_DEN, a[31:16]}, fraction_denominator);
      chk("seed", {a[15:0], a[31:16]}, modulator_seed);
      bus(0, `SDOC_IDX_NUM_HI, 16'h0000, r, d);
      chk("num_hi", {16'h0000, a[31:16]}, d);
    end
    lv = 16'($urandom);
    fc = 16'($urandom);
    bus(1, `SDOC_IDX_OUTA_LVL, lv, r, d);
    bus(1, `SDOC_IDX_OUTA_SRC, lv, r, d);
    bus(1, `SDOC_IDX_OUTB_SRC, fc, r, d);
    bus(1, `SDOC_IDX_FAST_CAL, fc, r, d);
    settle;
    chk("outs", {lv[`SDOC_F_OUTA_LVL], lv[`SDOC_F_OUTB_LVL], lv[`SDOC_B_OUTA_OFF],
        lv[`SDOC_B_OUTB_OFF], lv[`SDOC_F_OUTA_SRC], fc[`SDOC_F_OUTB_SRC], lv[`SDOC_F_ORDER],
        fc[`SDOC_B_FAST_AMP], fc[`SDOC_B_FAST_FRQ], fc[`SDOC_F_AMP_STEP], fc[`SDOC_F_FRQ_STEP]},
        {out_a_level, out_b_level, out_a_power_off, out_b_power_off, out_a_source, out_b_source,
        modulator_order, fast_amplitude_cal, fast_frequency_cal, amplitude_step,
        frequency_step});
    a = $urandom;
    tune_lock_pin <= 2'h2;
    cal_core_pin <= a[2:0] | 3'h1;
    cal_cap_pin <= a[15:8];
    cal_amp_pin <= a[24:16];
    settle;
    chk("stat_lock", 1'b1, status_pin);
    bus(0, `SDOC_IDX_RB_CORE, 16'h0000, r, d);
    chk("rb_core", {21'h0, 3'h4, a[2:0] | 3'h1, 5'h00}, d);
    bus(0, `SDOC_IDX_RB_CAP, 16'h0000, r, d);
    chk("rb_cap", {24'h0, a[15:8]}, d);
    bus(0, `SDOC_IDX_RB_AMP, 16'h0000, r, d);
    chk("rb_amp", {23'h0, a[24:16]}, d);
    bus(1, `SDOC_IDX_RB_CORE, 16'hffff, r, d);
    chk("ro_write", SDOC_RESP_SLVERR, r);
    bus(0, 7'h50, 16'h0000, r, d);
    chk("unmapped", {SDOC_RESP_SLVERR, 16'h0000}, {r, d[15:0]});
    bus(1, `SDOC_IDX_LD_SEL, 16'h0000, r, d);
    settle;
    chk("stat_cal0", 1'b0, status_pin);
    cal_done_pin <= 1;
    settle;
    chk("stat_cal1", 1'b1, status_pin);
    @(posedge aclk);
    clk_en <= 0;
    cal_done_pin <= 0;
    settle;
    chk("freeze", 2'b01, {s_axi_arready, status_pin});
    @(posedge aclk);
    clk_en <= 1;
    settle;
    chk("thaw", 1'b0, status_pin);
    end_sim();
  end
endmodule
